// ### logic/ctpm_map.svh
// Constants for the clock tree and power mode block.
// Assumes a single 200 MHz system clock; all other clocks arrive as pins.
`ifndef CTPM_MAP_SVH
`define CTPM_MAP_SVH

`define CTPM_CLK_MHZ       200
`define CTPM_SLEEP_WAKE_NS 15000
`define CTPM_HIB_WAKE_NS   100000
`define CTPM_SLEEP_WAKE_CYC ((`CTPM_SLEEP_WAKE_NS * `CTPM_CLK_MHZ) / 1000)
`define CTPM_HIB_WAKE_CYC   ((`CTPM_HIB_WAKE_NS * `CTPM_CLK_MHZ) / 1000)
`define CTPM_WATCH_HZ      32768

`define CTPM_A_SYSCFG   4'h0
`define CTPM_A_BUSDIV   4'h1
`define CTPM_A_CPUDIV   4'h2
`define CTPM_A_DIGCFG   4'h3
`define CTPM_A_DIGDIV   4'h4
`define CTPM_A_ANACFG   4'h5
`define CTPM_A_ANADIV   4'h6
`define CTPM_A_MODE     4'h7
`define CTPM_A_TPL_ACT  4'h8
`define CTPM_A_TPL_ALT  4'h9
`define CTPM_A_WAKEEN   4'ha
`define CTPM_A_STATUS   4'hb
`define CTPM_A_SECONDS  4'hc

`define CTPM_MODE_LSB   0
`define CTPM_SRC_LSB    0
`define CTPM_IDX_LSB    8
`define CTPM_SKEW_LSB   16
`define CTPM_USBSRC_BIT 4
`define CTPM_DIV_RST    16'h0001
`define CTPM_TPL_RST    8'hff
`define CTPM_CPU_BIT    0

`endif

// ### logic/ctpm_pkg.sv
// Types shared by the clock tree and power mode block.
// Assumes nothing of its surroundings.
package ctpm_pkg;
	typedef enum logic [1:0] {
		CTPM_ACTIVE,
		CTPM_ALT_ACTIVE,
		CTPM_SLEEP,
		CTPM_HIBERNATE
	} ctpm_mode_t;
	typedef enum logic [1:0] {
		CTPM_RUN,
		CTPM_WAKING
	} ctpm_wake_t;
endpackage

// ### logic/ctpm_divider.sv
// One clock divider: source mux, 16-bit ratio, resync and deglitch.
// Assumes sources are already synchronised strobes in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module ctpm_divider (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_src,
	input  wire logic [2:0]  i_sel,
	input  wire logic [15:0] i_ratio,
	input  wire logic [15:0] i_skew,
	input  wire logic        i_en,
	output logic             o_clk,
	output logic             o_tick
);
	logic [2:0]  sel_r;
	logic [15:0] ratio_r;
	logic [15:0] cnt_r;
	logic [15:0] skw_r;
	logic        src_d_r;
	logic        edge_w;
	logic        bound_w;
	logic [15:0] eff_w;

	always_comb
	begin
		eff_w = (i_ratio < 16'h0002) ? 16'h0002 : i_ratio;
	end

	// Source edges seen on the system clock only
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			src_d_r <= 1'b0;
		else
			src_d_r <= i_src[sel_r];
	end
	assign edge_w  = i_src[sel_r] & ~src_d_r;
	assign bound_w = edge_w && (cnt_r == ratio_r - 16'h0001);

	// New settings load only at a period end or while the output is low at count zero, so no runt pulse
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sel_r   <= 3'h0;
			ratio_r <= 16'h0002;
		end
		else if (bound_w || !o_clk && cnt_r == 16'h0000)
		begin
			sel_r   <= i_sel;
			ratio_r <= eff_w;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			cnt_r <= 16'h0000;
		else if (!i_en)
			cnt_r <= 16'h0000;
		else if (edge_w)
			cnt_r <= bound_w ? 16'h0000 : cnt_r + 16'h0001;
	end

	// High for the first half of the count, low for the rest
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			skw_r <= 16'h0000;
		else if (edge_w && cnt_r == 16'h0000)
			skw_r <= i_skew;
		else if (skw_r != 16'h0000)
			skw_r <= skw_r - 16'h0001;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_clk <= 1'b0;
		else if (!i_en)
			o_clk <= 1'b0;
		else if (skw_r <= 16'h0001)
			// Level follows the count only, so no mid-count source toggle leaks out
			o_clk <= cnt_r < (ratio_r >> 1);
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_tick <= 1'b0;
		else
			o_tick <= bound_w && i_en;
	end
endmodule
`default_nettype wire

// ### logic/ctpm_top.sv
// Clock tree and power mode controller with Avalon-MM register slave.
// Assumes external clocks arrive as pins, sampled on the 200 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
`include "ctpm_map.svh"
module ctpm_top (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [6:0]  i_clk_src,
	input  wire logic [7:0]  i_ic_clk,
	input  wire logic        i_irq_any,
	input  wire logic [5:0]  i_wake_evt,
	output logic             o_sys_clk_en,
	output logic             o_bus_clk,
	output logic             o_cpu_clk,
	output logic [7:0]       o_dig_clk,
	output logic [3:0]       o_ana_clk,
	output logic             o_usb_clk,
	output logic [7:0]       o_subsys_en,
	output logic [1:0]       o_mode,
	output logic             o_sleep_regs_on,
	output logic             o_hib_reg_only,
	output logic             o_second_irq
);
	// Sources: 0 internal main, 1 fast crystal, 2 doubler, 3 interconnect,
	// 4 PLL, 5 low speed internal, 6 watch crystal
	logic [6:0]  src_m_r;
	logic [6:0]  src_s_r;
	logic [7:0]  ic_m_r;
	logic [7:0]  ic_s_r;
	logic        irq_m_r;
	logic        irq_s_r;
	logic [5:0]  wk_m_r;
	logic [5:0]  wk_s_r;

	logic [2:0]  sys_sel_r;
	logic [15:0] bus_div_r;
	logic [15:0] cpu_div_r;
	logic [2:0]  dig_sel_r [8];
	logic [15:0] dig_div_r [8];
	logic [2:0]  ana_sel_r [4];
	logic [15:0] ana_div_r [4];
	logic [15:0] ana_skew_r [4];
	logic [2:0]  dig_idx_r;
	logic [1:0]  ana_idx_r;
	logic        usb_src_r;
	logic [7:0]  tpl_act_r;
	logic [7:0]  tpl_alt_r;
	logic [5:0]  wake_en_r;
	logic        sec_flag_r;
	logic [15:0] seconds_r;
	logic        rd_pend_r;

	ctpm_pkg::ctpm_mode_t mode_r;
	ctpm_pkg::ctpm_wake_t wst_r;
	logic [31:0] wake_cnt_r;
	logic        mode_wr_w;
	logic        wr_w;
	logic        hib_wake_w;
	logic        slp_wake_w;

	assign wr_w      = i_avs_write;
	assign mode_wr_w = wr_w && i_avs_address == `CTPM_A_MODE;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			src_m_r <= 7'h00;
			src_s_r <= 7'h00;
			ic_m_r  <= 8'h00;
			ic_s_r  <= 8'h00;
			irq_m_r <= 1'b0;
			irq_s_r <= 1'b0;
			wk_m_r  <= 6'h00;
			wk_s_r  <= 6'h00;
		end
		else
		begin
			src_m_r <= i_clk_src;
			src_s_r <= src_m_r;
			ic_m_r  <= i_ic_clk;
			ic_s_r  <= ic_m_r;
			irq_m_r <= i_irq_any;
			irq_s_r <= irq_m_r;
			wk_m_r  <= i_wake_evt;
			wk_s_r  <= wk_m_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sys_sel_r <= 3'h0;
			bus_div_r <= `CTPM_DIV_RST;
			cpu_div_r <= `CTPM_DIV_RST;
			dig_idx_r <= 3'h0;
			ana_idx_r <= 2'h0;
			usb_src_r <= 1'b0;
			tpl_act_r <= `CTPM_TPL_RST;
			tpl_alt_r <= `CTPM_TPL_RST;
			wake_en_r <= 6'h3f;
			for (int i = 0; i < 8; i++)
			begin
				dig_sel_r[i] <= 3'h0;
				dig_div_r[i] <= `CTPM_DIV_RST;
			end
			for (int i = 0; i < 4; i++)
			begin
				ana_sel_r[i]  <= 3'h0;
				ana_div_r[i]  <= `CTPM_DIV_RST;
				ana_skew_r[i] <= 16'h0000;
			end
		end
		else if (wr_w)
		begin
			unique case (i_avs_address)
				`CTPM_A_SYSCFG:
				begin
					sys_sel_r <= i_avs_writedata[`CTPM_SRC_LSB +: 3];
					usb_src_r <= i_avs_writedata[`CTPM_USBSRC_BIT];
				end
				`CTPM_A_BUSDIV:  bus_div_r <= i_avs_writedata[15:0];
				`CTPM_A_CPUDIV:  cpu_div_r <= i_avs_writedata[15:0];
				`CTPM_A_DIGCFG:
				begin
					dig_idx_r <= i_avs_writedata[`CTPM_IDX_LSB +: 3];
					dig_sel_r[i_avs_writedata[`CTPM_IDX_LSB +: 3]] <=
						i_avs_writedata[`CTPM_SRC_LSB +: 3];
				end
				`CTPM_A_DIGDIV:  dig_div_r[dig_idx_r] <= i_avs_writedata[15:0];
				`CTPM_A_ANACFG:
				begin
					ana_idx_r <= i_avs_writedata[`CTPM_IDX_LSB +: 2];
					ana_sel_r[i_avs_writedata[`CTPM_IDX_LSB +: 2]] <=
						i_avs_writedata[`CTPM_SRC_LSB +: 3];
					ana_skew_r[i_avs_writedata[`CTPM_IDX_LSB +: 2]] <=
						i_avs_writedata[`CTPM_SKEW_LSB +: 16];
				end
				`CTPM_A_ANADIV:  ana_div_r[ana_idx_r] <= i_avs_writedata[15:0];
				`CTPM_A_TPL_ACT: tpl_act_r <= i_avs_writedata[7:0];
				`CTPM_A_TPL_ALT: tpl_alt_r <= i_avs_writedata[7:0];
				`CTPM_A_WAKEEN:  wake_en_r <= i_avs_writedata[5:0];
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave: writes in one cycle, reads answered one cycle later
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			rd_pend_r <= 1'b0;
		else
			rd_pend_r <= i_avs_read && !rd_pend_r;
	end

	always_comb
	begin
		o_avs_waitrequest = i_avs_read && !rd_pend_r;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_avs_read && !rd_pend_r)
		begin
			unique case (i_avs_address)
				`CTPM_A_SYSCFG:  o_avs_readdata <= {27'h0, usb_src_r, 1'b0, sys_sel_r};
				`CTPM_A_BUSDIV:  o_avs_readdata <= {16'h0, bus_div_r};
				`CTPM_A_CPUDIV:  o_avs_readdata <= {16'h0, cpu_div_r};
				`CTPM_A_DIGCFG:  o_avs_readdata <= {21'h0, dig_idx_r, 5'h0,
					dig_sel_r[dig_idx_r]};
				`CTPM_A_DIGDIV:  o_avs_readdata <= {16'h0, dig_div_r[dig_idx_r]};
				`CTPM_A_ANACFG:  o_avs_readdata <= {ana_skew_r[ana_idx_r], 6'h0,
					ana_idx_r, 5'h0, ana_sel_r[ana_idx_r]};
				`CTPM_A_ANADIV:  o_avs_readdata <= {16'h0, ana_div_r[ana_idx_r]};
				`CTPM_A_MODE:    o_avs_readdata <= {30'h0, mode_r};
				`CTPM_A_TPL_ACT: o_avs_readdata <= {24'h0, tpl_act_r};
				`CTPM_A_TPL_ALT: o_avs_readdata <= {24'h0, tpl_alt_r};
				`CTPM_A_WAKEEN:  o_avs_readdata <= {26'h0, wake_en_r};
				`CTPM_A_STATUS:  o_avs_readdata <= {29'h0, sec_flag_r, wst_r};
				`CTPM_A_SECONDS: o_avs_readdata <= {16'h0, seconds_r};
				default:         o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Dividers
	logic [7:0]  all_src_w;
	logic        sys_w;
	logic        bus_w;
	logic        bus_tick_w;
	logic [7:0]  dig_w;
	logic [7:0]  dig_tick_w;
	logic        clk_run_w;

	assign clk_run_w = mode_r != ctpm_pkg::CTPM_HIBERNATE;
	assign all_src_w = {o_dig_clk[0], src_s_r};
	assign sys_w     = all_src_w[sys_sel_r];

	ctpm_divider u_bus (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_src     ({7'h00, sys_w}),
		.i_sel     (3'h0),
		.i_ratio   (bus_div_r),
		.i_skew    (16'h0000),
		.i_en      (clk_run_w),
		.o_clk     (bus_w),
		.o_tick    (bus_tick_w)
	);

	ctpm_divider u_cpu (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_src     ({7'h00, bus_w}),
		.i_sel     (3'h0),
		.i_ratio   (cpu_div_r),
		.i_skew    (16'h0000),
		.i_en      (clk_run_w && o_subsys_en[`CTPM_CPU_BIT]),
		.o_clk     (o_cpu_clk),
		.o_tick    ()
	);

	generate
		for (genvar g = 0; g < 8; g++)
		begin : g_dig
			ctpm_divider u_dig (
				.i_sys_clk (i_sys_clk),
				.i_rstn    (i_rstn),
				// Slot 7 takes the own interconnect clock
				.i_src     ({ic_s_r[g], src_s_r}),
				.i_sel     (dig_sel_r[g]),
				.i_ratio   (dig_div_r[g]),
				.i_skew    (16'h0000),
				.i_en      (clk_run_w),
				.o_clk     (dig_w[g]),
				.o_tick    (dig_tick_w[g])
			);
		end
		for (genvar g = 0; g < 4; g++)
		begin : g_ana
			ctpm_divider u_ana (
				.i_sys_clk (i_sys_clk),
				.i_rstn    (i_rstn),
				.i_src     (all_src_w),
				.i_sel     (ana_sel_r[g]),
				.i_ratio   (ana_div_r[g]),
				.i_skew    (ana_skew_r[g]),
				.i_en      (clk_run_w),
				.o_clk     (o_ana_clk[g]),
				.o_tick    ()
			);
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_bus_clk    <= 1'b0;
			o_dig_clk    <= 8'h00;
			o_sys_clk_en <= 1'b0;
			o_usb_clk    <= 1'b0;
		end
		else
		begin
			o_bus_clk    <= bus_w;
			o_dig_clk    <= dig_w;
			o_sys_clk_en <= sys_w && clk_run_w;
			// USB domain itself runs off this clock; bus side stays here
			o_usb_clk    <= clk_run_w && (usb_src_r ? src_s_r[3] : src_s_r[2]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calendar second from the watch crystal
	logic        watch_d_r;
	logic [14:0] watch_cnt_r;
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			watch_d_r   <= 1'b0;
			watch_cnt_r <= 15'h0000;
			sec_flag_r  <= 1'b0;
			seconds_r   <= 16'h0000;
		end
		else
		begin
			watch_d_r <= src_s_r[6];
			if (src_s_r[6] && !watch_d_r)
				watch_cnt_r <= watch_cnt_r + 15'h0001;
			if (src_s_r[6] && !watch_d_r && watch_cnt_r == 15'h7fff)
			begin
				sec_flag_r <= 1'b1;
				seconds_r  <= seconds_r + 16'h0001;
			end
			else if (i_avs_read && !rd_pend_r && i_avs_address == `CTPM_A_STATUS)
				sec_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_second_irq <= 1'b0;
		else
			o_second_irq <= src_s_r[6] && !watch_d_r && watch_cnt_r == 15'h7fff;
	end

	////////////////////////////////////////////////////////////////////////
	// Power modes
	assign hib_wake_w = wk_s_r[0] && wake_en_r[0];
	assign slp_wake_w = |(wk_s_r & wake_en_r);

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			mode_r     <= ctpm_pkg::CTPM_ACTIVE;
			wst_r      <= ctpm_pkg::CTPM_RUN;
			wake_cnt_r <= 32'h0;
		end
		else if (wst_r == ctpm_pkg::CTPM_WAKING)
		begin
			// Wake delay stands in for regulator settling
			if (wake_cnt_r <= 32'h1)
			begin
				mode_r <= ctpm_pkg::CTPM_ACTIVE;
				wst_r  <= ctpm_pkg::CTPM_RUN;
			end
			wake_cnt_r <= wake_cnt_r - 32'h1;
		end
		else
		begin
			unique case (mode_r)
				ctpm_pkg::CTPM_ACTIVE, ctpm_pkg::CTPM_ALT_ACTIVE:
					if (mode_wr_w)
						mode_r <= ctpm_pkg::ctpm_mode_t'(i_avs_writedata[1:0]);
					else if (mode_r == ctpm_pkg::CTPM_ALT_ACTIVE && irq_s_r)
						mode_r <= ctpm_pkg::CTPM_ACTIVE;
				ctpm_pkg::CTPM_SLEEP:
					if (slp_wake_w || irq_s_r)
					begin
						wst_r      <= ctpm_pkg::CTPM_WAKING;
						wake_cnt_r <= 32'(`CTPM_SLEEP_WAKE_CYC - 1);
					end
				ctpm_pkg::CTPM_HIBERNATE:
					if (hib_wake_w)
					begin
						wst_r      <= ctpm_pkg::CTPM_WAKING;
						wake_cnt_r <= 32'(`CTPM_HIB_WAKE_CYC - 1);
					end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_subsys_en     <= `CTPM_TPL_RST;
			o_mode          <= 2'h0;
			o_sleep_regs_on <= 1'b0;
			o_hib_reg_only  <= 1'b0;
		end
		else
		begin
			o_mode <= mode_r;
			unique case (mode_r)
				ctpm_pkg::CTPM_ACTIVE:
					o_subsys_en <= tpl_act_r | 8'h01;
				ctpm_pkg::CTPM_ALT_ACTIVE:
					o_subsys_en <= tpl_alt_r;
				ctpm_pkg::CTPM_SLEEP:
					o_subsys_en <= 8'h00;
				ctpm_pkg::CTPM_HIBERNATE:
					o_subsys_en <= 8'h00;
			endcase
			o_sleep_regs_on <= mode_r == ctpm_pkg::CTPM_SLEEP;
			o_hib_reg_only  <= mode_r == ctpm_pkg::CTPM_HIBERNATE;
		end
	end
endmodule
`default_nettype wire

// ### dv/ctpm_props_properties.sv
// Port assertions for the clock tree and power mode block.
// Assumes binding to ctpm_top; one 200 MHz domain.
`timescale 1ns/1ps
`default_nettype none
module ctpm_props (
	input wire logic       i_sys_clk,
	input wire logic       i_rstn,
	input wire logic       i_avs_read,
	input wire logic       i_avs_write,
	input wire logic       o_avs_waitrequest,
	input wire logic       i_irq_any,
	input wire logic [5:0] i_wake_evt,
	input wire logic [7:0] o_subsys_en,
	input wire logic [1:0] o_mode,
	input wire logic       o_hib_reg_only,
	input wire logic       o_second_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	logic [15:0] slp_r;
	logic [15:0] hib_r;
	////////////////////////////////////////////////////////////////
	// Wake waits counted here, too long for a delay range
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			slp_r <= 16'h0000;
			hib_r <= 16'h0000;
		end
		else
		begin
			slp_r <= (o_mode == 2'd2 && i_wake_evt[1]) ? slp_r + 16'h0001 : 16'h0000;
			hib_r <= (o_mode == 2'd3 && i_wake_evt[0]) ? hib_r + 16'h0001 : 16'h0000;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_wr_fast;
		i_avs_write |-> !o_avs_waitrequest;
	endproperty
	a_wr_fast: assert property (p_wr_fast)
		else $error("write stalled");
	property p_rd_wait;
		$rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait state wrong");
	property p_cpu_act;
		o_mode == 2'd0 && $past(o_mode) == 2'd0 |-> o_subsys_en[0];
	endproperty
	a_cpu_act: assert property (p_cpu_act)
		else $error("cpu off in active");
	property p_alt_irq;
		o_mode == 2'd1 && i_irq_any |-> ##[1:4] o_mode == 2'd0;
	endproperty
	a_alt_irq: assert property (p_alt_irq)
		else $error("alternate mode kept on interrupt");
	property p_alt_by_wr;
		$changed(o_mode) && o_mode == 2'd1
			|-> $past(i_avs_write, 1) || $past(i_avs_write, 2) || $past(i_avs_write, 3);
	endproperty
	a_alt_by_wr: assert property (p_alt_by_wr)
		else $error("alternate mode without write");
	property p_wake_act;
		$fell(o_mode[1]) |-> o_mode == 2'd0;
	endproperty
	a_wake_act: assert property (p_wake_act)
		else $error("wake not to active");
	property p_hib_reg;
		o_mode == 2'd3 && $past(o_mode) == 2'd3 |-> o_hib_reg_only;
	endproperty
	a_hib_reg: assert property (p_hib_reg)
		else $error("regulators on in hibernate");
	property p_sec_pulse;
		o_second_irq |=> !o_second_irq;
	endproperty
	a_sec_pulse: assert property (p_sec_pulse)
		else $error("second tick too long");
	property p_slp_bound;
		slp_r <= 16'd3010;
	endproperty
	a_slp_bound: assert property (p_slp_bound)
		else $error("sleep wake too slow");
	property p_hib_bound;
		hib_r <= 16'd20010;
	endproperty
	a_hib_bound: assert property (p_hib_bound)
		else $error("hibernate wake too slow");
endmodule
bind ctpm_top ctpm_props u_ctpm_props (.i_sys_clk, .i_rstn, .i_avs_read, .i_avs_write,
	.o_avs_waitrequest, .i_irq_any, .i_wake_evt, .o_subsys_en, .o_mode, .o_hib_reg_only,
	.o_second_irq);
`default_nettype wire

// ### dv/ctpm_periph_model.sv
// Clock sources and a bus clock consumer around the block.
// Assumes the bench clock; measures bus clock level runs.
`timescale 1ns/1ps
`default_nettype none
module ctpm_periph_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_bus_clk,
	output logic [6:0]      o_src,
	output logic [7:0]      o_ic,
	output int              o_hi,
	output int              o_lo
);
	int   run = 0;
	logic prev = 1'b0;
	// All sources run; watch edge every second cycle
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_src <= 7'h00;
			o_ic  <= 8'h00;
		end
		else
		begin
			o_src <= ~o_src;
			o_ic  <= ~o_ic;
		end
	end
	// Sampled mid-cycle so the level is settled
	always @(negedge i_sys_clk)
	begin
		if (i_bus_clk !== prev)
		begin
			if (prev)
				o_hi = run;
			else
				o_lo = run;
			run = 0;
		end
		run  = run + 1;
		prev = i_bus_clk;
	end
endmodule
`default_nettype wire

// ### dv/test_clock_tree_and_power_modes.sv
// Self-checking bench for the clock tree and power mode block.
// Assumes ctpm_top with its bound checker and the peripheral model.
`timescale 1ns/1ps
`default_nettype none
`include "ctpm_map.svh"
module test_clock_tree_and_power_modes;
	logic        clk;
	logic        rstn;
	logic [3:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wait_rq;
	logic [6:0]  src;
	logic [7:0]  ic;
	logic        irq;
	logic [5:0]  wake;
	logic        bus_clk;
	logic [7:0]  subsys;
	logic [1:0]  mode;
	logic        hib_only;
	logic        slp_on;
	logic        sec;
	logic [31:0] seed;
	logic [31:0] v;
	int          hi;
	int          lo;
	int          mismatches;
	int          checks;
	int          secs;
	int          k;
	int          regs [int];
	ctpm_top u_ctpm_top (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_rq), .i_clk_src(src), .i_ic_clk(ic), .i_irq_any(irq),
		.i_wake_evt(wake), .o_sys_clk_en(), .o_bus_clk(bus_clk), .o_cpu_clk(), .o_dig_clk(),
		.o_ana_clk(), .o_usb_clk(), .o_subsys_en(subsys), .o_mode(mode),
		.o_sleep_regs_on(slp_on), .o_hib_reg_only(hib_only), .o_second_irq(sec));
	ctpm_periph_model u_ctpm_periph_model (.i_sys_clk(clk), .i_rstn(rstn), .i_bus_clk(bus_clk),
		.o_src(src), .o_ic(ic), .o_hi(hi), .o_lo(lo));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk) if (sec === 1'b1) secs++;
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, exp, seen);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Held until waitrequest is seen low before the edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		@(negedge clk);
		while (wait_rq !== 1'b0 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 50)
		begin
			mismatches++;
			results();
		end
		@(posedge clk);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wait_mode(input logic [1:0] m, input int lim);
		int n;
		n = 0;
		while (mode !== m && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= lim)
		begin
			mismatches++;
			results();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'h3fdced1e;
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		irq = 1'b0;
		wake = 6'h00;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("mode", mode, 32'h0);
		chk("subsys", subsys, 32'hff);
		bus(0, `CTPM_A_WAKEEN, 0, v);
		chk("wakeen", v, 32'h3f);
		bus(0, 4'hd, 0, v);
		chk("unmapped", v, 32'h0);
		// Cpu bit left clear so forced enable shows
		for (k = 8; k < 10; k++)
		begin
			regs[k] = rnd() & 32'hfe;
			bus(1, k[3:0], regs[k], v);
			bus(0, k[3:0], 0, v);
			chk("template", v, regs[k]);
		end
		@(negedge clk);
		chk("act en", subsys, regs[8] | 1);
		bus(1, `CTPM_A_SYSCFG, 32'h0, v);
		bus(1, `CTPM_A_BUSDIV, 32'h4, v);
		repeat (300) @(posedge clk);
		// Source toggles every cycle, ratio 4: four cycles high, four low
		chk("bus hi", hi, 4);
		chk("bus lo", lo, 4);
		bus(1, `CTPM_A_MODE, 32'h1, v);
		wait_mode(1, 10);
		@(negedge clk);
		chk("alt en", subsys, regs[9]);
		@(posedge clk);
		irq <= 1'b1;
		wait_mode(0, 10);
		@(posedge clk);
		irq <= 1'b0;
		@(negedge clk);
		chk("cpu on", subsys[0], 1);
		bus(1, `CTPM_A_MODE, 32'h2, v);
		wait_mode(2, 10);
		@(negedge clk);
		chk("sleep cpu", subsys[0], 0);
		chk("sleep reg", slp_on, 1);
		@(posedge clk);
		wake <= 6'h02;
		wait_mode(0, 3100);
		@(posedge clk);
		wake <= 6'h00;
		bus(1, `CTPM_A_MODE, 32'h3, v);
		wait_mode(3, 10);
		// Every source but the pin, plus an interrupt
		@(posedge clk);
		wake <= 6'h3e;
		irq  <= 1'b1;
		repeat (100) @(posedge clk);
		irq  <= 1'b0;
		wake <= 6'h01;
		@(negedge clk);
		chk("hib hold", mode, 3);
		chk("sleep reg off", slp_on, 0);
		chk("hib reg", hib_only, 1);
		wait_mode(0, 20100);
		@(posedge clk);
		wake <= 6'h00;
		@(negedge clk);
		chk("cpu back", subsys[0], 1);
		k = 0;
		while (secs == 0 && k < 70000)
		begin
			@(negedge clk);
			k++;
		end
		chk("got tick", secs > 0, 1);
		bus(0, `CTPM_A_SECONDS, 0, v);
		chk("seconds", v, secs);
		bus(0, `CTPM_A_STATUS, 0, v);
		chk("flag", v[2], 1);
		bus(0, `CTPM_A_STATUS, 0, v);
		chk("flag clr", v[2], 0);
		results();
	end
endmodule
`default_nettype wire
